// *** cmd_check.sv ***
// Length and content check of one command packet
`default_nettype none
module cmd_check (
  // Packet header
  input  wire logic [1:0]  cls,
  input  wire logic [5:0]  code,
  input  wire logic [7:0]  len,
  // First three payload bytes
  input  wire logic [23:0] magic,
  // Verdict
  output logic             ok,
  output cmd_decoder_pkg::action_e act
);
  logic len_ok;
  logic body_ok;

  // Length per code, magic triples for restart
  always_comb begin
    len_ok  = 1'b0;
    body_ok = 1'b1;
    act     = cmd_decoder_pkg::ACT_NONE;
    unique case (code)
      cmd_decoder_pkg::CODE_PING:  len_ok = (len <= cmd_decoder_pkg::LEN_FIELD);
      cmd_decoder_pkg::CODE_VER,
      cmd_decoder_pkg::CODE_NVRD,
      cmd_decoder_pkg::CODE_BOOT,
      cmd_decoder_pkg::CODE_CLR:   len_ok = (len == cmd_decoder_pkg::LEN_ZERO);
      cmd_decoder_pkg::CODE_NVWR,
      cmd_decoder_pkg::CODE_LINE1,
      cmd_decoder_pkg::CODE_LINE2: len_ok = (len == cmd_decoder_pkg::LEN_FIELD);
      cmd_decoder_pkg::CODE_RST: begin
        len_ok = (len == cmd_decoder_pkg::LEN_MAGIC);
        if (magic == cmd_decoder_pkg::MAGIC_REBOOT) begin
          act = cmd_decoder_pkg::ACT_REBOOT;
        end else if (magic == cmd_decoder_pkg::MAGIC_HRST) begin
          act = cmd_decoder_pkg::ACT_HRST;
        end else if (magic == cmd_decoder_pkg::MAGIC_POFF) begin
          act = cmd_decoder_pkg::ACT_POFF;
        end else begin
          body_ok = 1'b0;
        end
      end
      default: len_ok = 1'b0;
    endcase
  end

  // Only well formed command-class packets pass
  assign ok = len_ok && body_ok && (cls == cmd_decoder_pkg::CLASS_CMD) &&
              (len <= cmd_decoder_pkg::LEN_MAX);
endmodule // cmd_check
`default_nettype wire

// *** cmd_decoder_pkg.sv ***
// Shared constants and types of the display command interpreter
`default_nettype none
package cmd_decoder_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned BOOT_HOLD_MS  = 3000;
  localparam int unsigned HOST_RST_MS   = 1500;
  localparam int unsigned BOOT_HOLD_CYC = BOOT_HOLD_MS * CYC_PER_MS;
  localparam int unsigned HOST_RST_CYC  = HOST_RST_MS * CYC_PER_MS;
  // ----------------------------------------------------------------
  // Packet fields
  // ----------------------------------------------------------------
  localparam logic [1:0] CLASS_CMD  = 2'h0;
  localparam logic [1:0] CLASS_RSP  = 2'h1;
  localparam logic [1:0] CLASS_ERR  = 2'h3;
  localparam logic [7:0] LEN_ZERO   = 8'h00;
  localparam logic [7:0] LEN_FIELD  = 8'h10;
  localparam logic [7:0] LEN_MAGIC  = 8'h03;
  localparam logic [7:0] LEN_MAX    = 8'h12;
  localparam int         FIELD_N    = 16;
  localparam logic [5:0] CODE_PING  = 6'h00;
  localparam logic [5:0] CODE_VER   = 6'h01;
  localparam logic [5:0] CODE_NVWR  = 6'h02;
  localparam logic [5:0] CODE_NVRD  = 6'h03;
  localparam logic [5:0] CODE_BOOT  = 6'h04;
  localparam logic [5:0] CODE_RST   = 6'h05;
  localparam logic [5:0] CODE_CLR   = 6'h06;
  localparam logic [5:0] CODE_LINE1 = 6'h07;
  localparam logic [5:0] CODE_LINE2 = 6'h08;
  // Magic triples of the restart command
  localparam logic [23:0] MAGIC_REBOOT = {8'h08, 8'h12, 8'h63};
  localparam logic [23:0] MAGIC_HRST   = {8'h0c, 8'h1c, 8'h61};
  localparam logic [23:0] MAGIC_POFF   = {8'h03, 8'h0b, 8'h5f};
  // ----------------------------------------------------------------
  // Display and identity
  // ----------------------------------------------------------------
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam int         DISP_N     = 32;
  localparam int         LINE2_BASE = 16;
  // Version string; the value is arbitrary
  localparam logic [127:0] VERSION_STR = "DISPLAY:h0.0,a00";
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RX = 3'b001, ST_EXEC = 3'b011, ST_HDR = 3'b010,
    ST_TX = 3'b110, ST_POST = 3'b111, ST_HOLD = 3'b101
  } state_e;
  typedef enum logic [1:0] {ACT_NONE, ACT_REBOOT, ACT_HRST, ACT_POFF} action_e;
  typedef enum logic [1:0] {SRC_BUF, SRC_VER, SRC_NV} src_e;
endpackage
`default_nettype wire

// *** decoder_monitor.sv ***
// Port checker of the display command interpreter
`default_nettype none
module decoder_monitor #(
  parameter int unsigned BOOT_HOLD_CYCLES = 20,
  parameter int unsigned HOST_RST_CYCLES  = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Headers
  input wire logic        in_hdr_valid,
  input wire logic        in_hdr_ready,
  input wire logic [7:0]  in_type,
  input wire logic [7:0]  in_len,
  input wire logic        out_hdr_valid,
  input wire logic [7:0]  out_type,
  input wire logic [7:0]  out_len,
  // Cursor, pins and events
  input wire logic [3:0]  cursor_col,
  input wire logic        cursor_row,
  input wire logic        gpio2_user,
  input wire logic [31:0] pwr_pulse_cycles,
  input wire logic        host_rst_out,
  input wire logic        host_pwr_out,
  input wire logic        restart
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cmd_type;
  logic [31:0] rst_cnt;
  logic [31:0] pwr_cnt;
  // ------------
  // Helper state
  // ------------
  // Last command type and lengths of the pin pulses
  always_ff @(posedge clk) begin
    cmd_type <= sys_rst ? 8'h00 : (in_hdr_valid && in_hdr_ready) ? in_type : cmd_type;
    rst_cnt  <= (sys_rst || !host_rst_out) ? 32'h0 : rst_cnt + 32'h1;
    pwr_cnt  <= (sys_rst || !host_pwr_out) ? 32'h0 : pwr_cnt + 32'h1;
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  type_keep_a: assert property (out_hdr_valid |-> out_type[5:0] == cmd_type[5:0])
    else $error("answer code wrong");
  answer_class_a: assert property (out_hdr_valid |-> out_type[7:6] inside {2'h1, 2'h3})
    else $error("answer class wrong");
  error_empty_a: assert property (out_hdr_valid && out_type[7:6] == 2'h3 |-> out_len == 8'h00)
    else $error("error answer not empty");
  quick_answer_a: assert property (in_hdr_valid && in_hdr_ready && in_len == 8'h00 |-> ##2 out_hdr_valid)
    else $error("answer late");
  restart_hold_a: assert property (restart |-> !in_hdr_ready [*8])
    else $error("command taken during hold");
  rst_len_a: assert property ($fell(host_rst_out) |-> rst_cnt == HOST_RST_CYCLES)
    else $error("host reset length wrong");
  pwr_len_a: assert property ($fell(host_pwr_out) |-> pwr_cnt == pwr_pulse_cycles)
    else $error("power pulse length wrong");
  pin_user_a: assert property (gpio2_user && $past(gpio2_user) |-> !host_pwr_out)
    else $error("power pin driven while user owned");
  clear_home_a: assert property (out_hdr_valid && out_type == 8'h46 |-> cursor_col == 4'h0 && !cursor_row)
    else $error("cursor not home after clear");
  cover property (restart);
  cover property ($fell(host_pwr_out));
  cover property (out_hdr_valid && out_type[7:6] == 2'h3);
endmodule // decoder_monitor
`default_nettype wire

// *** display_module_command_decoder.sv ***
// Command interpreter of the serial character-display module
`default_nettype none
module display_module_command_decoder #(
  parameter int unsigned BOOT_HOLD_CYCLES = cmd_decoder_pkg::BOOT_HOLD_CYC,
  parameter int unsigned HOST_RST_CYCLES  = cmd_decoder_pkg::HOST_RST_CYC
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Command header from the framing engine
  input  wire logic        in_hdr_valid,
  output logic             in_hdr_ready,
  input  wire logic [7:0]  in_type,
  input  wire logic [7:0]  in_len,
  // Command payload bytes
  input  wire logic        in_byte_valid,
  output logic             in_byte_ready,
  input  wire logic [7:0]  in_byte,
  // Answer header to the framing engine
  output logic             out_hdr_valid,
  input  wire logic        out_hdr_ready,
  output logic [7:0]       out_type,
  output logic [7:0]       out_len,
  // Answer payload bytes
  output logic             out_byte_valid,
  input  wire logic        out_byte_ready,
  output logic [7:0]       out_byte,
  // Display character read port and cursor
  input  wire logic [4:0]  disp_rd_addr,
  output logic [7:0]       disp_rd_char,
  output logic [3:0]       cursor_col,
  output logic             cursor_row,
  // Host control pins and their configuration
  input  wire logic        gpio2_user,
  input  wire logic        gpio3_user,
  input  wire logic [31:0] pwr_pulse_cycles,
  output logic             host_rst_out,
  output logic             host_pwr_out,
  // Events to the rest of the module
  output logic             boot_store,
  output logic             restart
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  cmd_decoder_pkg::state_e  state;
  cmd_decoder_pkg::action_e act_q;
  cmd_decoder_pkg::action_e chk_act;
  cmd_decoder_pkg::src_e    src;
  logic [7:0] pbuf [cmd_decoder_pkg::FIELD_N];
  logic [7:0] nv_area [cmd_decoder_pkg::FIELD_N];
  logic [7:0] display_char_memory [cmd_decoder_pkg::DISP_N];
  logic [7:0] boot_disp [cmd_decoder_pkg::DISP_N];
  logic [3:0] boot_col;
  logic       boot_row;
  logic [1:0] cls_q;
  logic [5:0] code_q;
  logic [7:0] len_q;
  logic [7:0] cnt;
  logic       chk_ok;
  logic       run_ok;
  logic       pkt_done;
  logic       restart_now;
  logic       tmr_load;
  logic [31:0] tmr_val;
  logic       tmr_expired;

  // Answer byte by source and index
  function automatic logic [7:0] rsp_byte(input cmd_decoder_pkg::src_e s,
                                          input logic [3:0] i);
    if (s == cmd_decoder_pkg::SRC_VER) begin
      rsp_byte = cmd_decoder_pkg::VERSION_STR[8 * (15 - int'(i)) +: 8];
    end else if (s == cmd_decoder_pkg::SRC_NV) begin
      rsp_byte = nv_area[i];
    end else begin
      rsp_byte = pbuf[i];
    end
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  cmd_check u_check (
    .cls   (cls_q),
    .code  (code_q),
    .len   (len_q),
    .magic ({pbuf[0], pbuf[1], pbuf[2]}),
    .ok    (chk_ok),
    .act   (chk_act)
  );

  hold_timer u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  // ----------------------------------------------------------------
  // Handshakes and sequencing terms
  // ----------------------------------------------------------------
  assign in_hdr_ready   = clk_en && (state == cmd_decoder_pkg::ST_IDLE);
  assign in_byte_ready  = clk_en && (state == cmd_decoder_pkg::ST_RX);
  // Valids drop with the enable, so no transfer is seen while state is frozen
  assign out_hdr_valid  = clk_en && (state == cmd_decoder_pkg::ST_HDR);
  assign out_byte_valid = clk_en && (state == cmd_decoder_pkg::ST_TX);
  assign run_ok         = (state == cmd_decoder_pkg::ST_EXEC) && chk_ok;
  assign pkt_done = clk_en &&
    (((state == cmd_decoder_pkg::ST_HDR) && out_hdr_ready && (out_len == '0)) ||
     ((state == cmd_decoder_pkg::ST_TX) && out_byte_ready && (cnt == out_len - 8'h1)));
  assign restart_now = clk_en && (state == cmd_decoder_pkg::ST_POST) && tmr_expired;
  assign tmr_load = restart_now || (pkt_done && (act_q != cmd_decoder_pkg::ACT_NONE));

  // Timer figure: pin time after the answer, hold-off after restart
  always_comb begin
    tmr_val = '0;
    if (restart_now) begin
      tmr_val = 32'(BOOT_HOLD_CYCLES);
    end else if (act_q == cmd_decoder_pkg::ACT_HRST) begin
      tmr_val = 32'(HOST_RST_CYCLES);
    end else if (act_q == cmd_decoder_pkg::ACT_POFF) begin
      tmr_val = pwr_pulse_cycles;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= cmd_decoder_pkg::ST_IDLE;
    end else if (clk_en) begin
      unique case (state)
        cmd_decoder_pkg::ST_IDLE:
          if (in_hdr_valid) begin
            state <= (in_len == '0) ? cmd_decoder_pkg::ST_EXEC : cmd_decoder_pkg::ST_RX;
          end
        cmd_decoder_pkg::ST_RX:
          if (in_byte_valid && (cnt == len_q - 8'h1)) begin
            state <= cmd_decoder_pkg::ST_EXEC;
          end
        cmd_decoder_pkg::ST_EXEC: state <= cmd_decoder_pkg::ST_HDR;
        cmd_decoder_pkg::ST_HDR, cmd_decoder_pkg::ST_TX:
          if (pkt_done) begin
            state <= (act_q == cmd_decoder_pkg::ACT_NONE) ?
                     cmd_decoder_pkg::ST_IDLE : cmd_decoder_pkg::ST_POST;
          end else if (out_hdr_ready && (state == cmd_decoder_pkg::ST_HDR)) begin
            state <= cmd_decoder_pkg::ST_TX;
          end
        cmd_decoder_pkg::ST_POST:
          if (tmr_expired) begin
            state <= cmd_decoder_pkg::ST_HOLD;
          end
        cmd_decoder_pkg::ST_HOLD:
          if (tmr_expired) begin
            state <= cmd_decoder_pkg::ST_IDLE;
          end
        default: state <= cmd_decoder_pkg::ST_IDLE;
      endcase
    end
  end

  // Header capture and byte counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cls_q  <= '0;
      code_q <= '0;
      len_q  <= '0;
      cnt    <= '0;
    end else if (clk_en) begin
      if (in_hdr_ready && in_hdr_valid) begin
        cls_q  <= in_type[7:6];
        code_q <= in_type[5:0];
        len_q  <= in_len;
        cnt    <= '0;
      end else if (in_byte_ready && in_byte_valid) begin
        cnt <= cnt + 8'h1;
      end else if (state == cmd_decoder_pkg::ST_HDR) begin
        cnt <= '0;
      end else if ((state == cmd_decoder_pkg::ST_TX) && out_byte_ready) begin
        cnt <= cnt + 8'h1;
      end
    end
  end

  // Payload buffer; bytes past the sixteenth are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pbuf <= '{default: '0};
    end else if (clk_en && in_byte_ready && in_byte_valid && (cnt < 8'(cmd_decoder_pkg::FIELD_N))) begin
      pbuf[cnt[3:0]] <= in_byte;
    end
  end

  // ----------------------------------------------------------------
  // Answer building
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_type <= '0;
      out_len  <= '0;
      src      <= cmd_decoder_pkg::SRC_BUF;
      act_q    <= cmd_decoder_pkg::ACT_NONE;
    end else if (clk_en && (state == cmd_decoder_pkg::ST_EXEC)) begin
      out_len <= '0;
      src     <= cmd_decoder_pkg::SRC_BUF;
      act_q   <= cmd_decoder_pkg::ACT_NONE;
      if (!chk_ok) begin
        out_type <= {cmd_decoder_pkg::CLASS_ERR, code_q};
      end else begin
        out_type <= {cmd_decoder_pkg::CLASS_RSP, code_q};
        act_q    <= chk_act;
        if (code_q == cmd_decoder_pkg::CODE_PING) begin
          out_len <= len_q;
        end else if (code_q == cmd_decoder_pkg::CODE_VER) begin
          out_len <= cmd_decoder_pkg::LEN_FIELD;
          src     <= cmd_decoder_pkg::SRC_VER;
        end else if (code_q == cmd_decoder_pkg::CODE_NVRD) begin
          out_len <= cmd_decoder_pkg::LEN_FIELD;
          src     <= cmd_decoder_pkg::SRC_NV;
        end
      end
    end
  end

  // Registered answer byte, next one fetched on each accept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_byte <= '0;
    end else if (clk_en) begin
      if ((state == cmd_decoder_pkg::ST_HDR) && out_hdr_ready) begin
        out_byte <= rsp_byte(src, 4'h0);
      end else if ((state == cmd_decoder_pkg::ST_TX) && out_byte_ready) begin
        out_byte <= rsp_byte(src, cnt[3:0] + 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Host storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nv_area <= '{default: '0};
    end else if (clk_en && run_ok && (code_q == cmd_decoder_pkg::CODE_NVWR)) begin
      nv_area <= pbuf;
    end
  end

  // ----------------------------------------------------------------
  // Display memory, cursor and boot image
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      display_char_memory <= '{default: cmd_decoder_pkg::BLANK_CHAR};
      cursor_col <= '0;
      cursor_row <= 1'b0;
    end else if (clk_en) begin
      if (restart_now) begin
        display_char_memory <= boot_disp;
        cursor_col <= boot_col;
        cursor_row <= boot_row;
      end else if (run_ok && (code_q == cmd_decoder_pkg::CODE_CLR)) begin
        display_char_memory <= '{default: cmd_decoder_pkg::BLANK_CHAR};
        cursor_col <= '0;
        cursor_row <= 1'b0;
      end else if (run_ok && (code_q == cmd_decoder_pkg::CODE_LINE1)) begin
        for (int i = 0; i < cmd_decoder_pkg::FIELD_N; i++) begin
          display_char_memory[i] <= pbuf[i];
        end
      end else if (run_ok && (code_q == cmd_decoder_pkg::CODE_LINE2)) begin
        for (int i = 0; i < cmd_decoder_pkg::FIELD_N; i++) begin
          display_char_memory[cmd_decoder_pkg::LINE2_BASE + i] <= pbuf[i];
        end
      end
    end
  end

  // Boot image holds display and cursor only; reporting is not kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_disp  <= '{default: cmd_decoder_pkg::BLANK_CHAR};
      boot_col   <= '0;
      boot_row   <= 1'b0;
      boot_store <= 1'b0;
    end else if (clk_en) begin
      boot_store <= run_ok && (code_q == cmd_decoder_pkg::CODE_BOOT);
      if (run_ok && (code_q == cmd_decoder_pkg::CODE_BOOT)) begin
        boot_disp <= display_char_memory;
        boot_col  <= cursor_col;
        boot_row  <= cursor_row;
      end
    end
  end

  // Display read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disp_rd_char <= '0;
    end else if (clk_en) begin
      disp_rd_char <= display_char_memory[disp_rd_addr];
    end
  end

  // ----------------------------------------------------------------
  // Host pins and restart event
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_rst_out <= 1'b0;
      host_pwr_out <= 1'b0;
      restart      <= 1'b0;
    end else if (clk_en) begin
      host_rst_out <= (state == cmd_decoder_pkg::ST_POST) && !tmr_expired &&
                      (act_q == cmd_decoder_pkg::ACT_HRST) && !gpio3_user;
      host_pwr_out <= (state == cmd_decoder_pkg::ST_POST) && !tmr_expired &&
                      (act_q == cmd_decoder_pkg::ACT_POFF) && !gpio2_user;
      restart      <= restart_now;
    end
  end
endmodule // display_module_command_decoder
`default_nettype wire

// *** display_module_command_decoder_test.sv ***
// Self-checking bench of the display command interpreter
`default_nettype none
module display_module_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RST_CYC = 10;
  localparam int unsigned PWR_CYC = 5;
  logic        clk, sys_rst, clk_en, slow, gpio2_user, gpio3_user;
  logic        in_hdr_valid, in_hdr_ready, in_byte_valid, in_byte_ready, restart;
  logic        out_hdr_valid, out_hdr_ready, out_byte_valid, out_byte_ready, boot_store;
  logic        cursor_row, host_rst_out, host_pwr_out;
  logic [7:0]  in_type, in_len, in_byte, out_type, out_len, out_byte, disp_rd_char;
  logic [4:0]  disp_rd_addr;
  logic [3:0]  cursor_col;
  logic [31:0] pwr_pulse_cycles;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  int          n_boot = 0, n_rest = 0, hi_rst = 0, hi_pwr = 0;
  // ---------------
  // Design and host
  // ---------------
  display_module_command_decoder #(.BOOT_HOLD_CYCLES(20), .HOST_RST_CYCLES(RST_CYC)) DUT (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .in_hdr_valid(in_hdr_valid),
    .in_hdr_ready(in_hdr_ready), .in_type(in_type), .in_len(in_len),
    .in_byte_valid(in_byte_valid), .in_byte_ready(in_byte_ready), .in_byte(in_byte),
    .out_hdr_valid(out_hdr_valid), .out_hdr_ready(out_hdr_ready), .out_type(out_type),
    .out_len(out_len), .out_byte_valid(out_byte_valid), .out_byte_ready(out_byte_ready),
    .out_byte(out_byte), .disp_rd_addr(disp_rd_addr), .disp_rd_char(disp_rd_char),
    .cursor_col(cursor_col), .cursor_row(cursor_row), .gpio2_user(gpio2_user),
    .gpio3_user(gpio3_user), .pwr_pulse_cycles(pwr_pulse_cycles),
    .host_rst_out(host_rst_out), .host_pwr_out(host_pwr_out), .boot_store(boot_store),
    .restart(restart));
  host_model HOST (
    .clk(clk), .slow(slow), .hdr_v(in_hdr_valid), .hdr_r(in_hdr_ready), .typ(in_type),
    .len(in_len), .byt_v(in_byte_valid), .byt_r(in_byte_ready), .byt(in_byte),
    .ans_v(out_hdr_valid), .ans_r(out_hdr_ready), .ans_typ(out_type), .ans_len(out_len),
    .ab_v(out_byte_valid), .ab_r(out_byte_ready), .ab(out_byte));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event tally and run ceiling
  always @(posedge clk) begin
    cyc++;
    n_boot += (boot_store === 1'b1);
    n_rest += (restart === 1'b1);
    hi_rst += (host_rst_out === 1'b1);
    hi_pwr += (host_pwr_out === 1'b1);
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // -------------
  // Shared tasks
  // -------------
  task check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd(input logic [7:0] t, input logic [7:0] l, input logic [7:0] et);
    HOST.xfer(t, l);
    check8(HOST.r_typ, et);
    check8(HOST.r_len, (et[7:6] != 2'h1) ? 8'h00 : (t == 8'h00) ? l :
                       (t inside {8'h01, 8'h03}) ? 8'h10 : 8'h00);
  endtask
  task fill(input logic [7:0] b);
    for (int i = 0; i < 19; i++) HOST.tx[i] = b + i[7:0];
  endtask
  task magic(input logic [23:0] m);
    {HOST.tx[0], HOST.tx[1], HOST.tx[2]} = m;
  endtask
  task rd_disp(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    disp_rd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check8(disp_rd_char, e);
  endtask
  task complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------
  // Scenarios
  // ---------
  task t_echo_version;
    fill(8'ha0);
    cmd(8'h00, 8'h10, 8'h40);
    for (int i = 0; i < 16; i++) check8(HOST.rx[i], 8'ha0 + i[7:0]);
    cmd(8'h00, 8'h00, 8'h40);
    cmd(8'h01, 8'h00, 8'h41);
    for (int i = 0; i < 16; i++) check8(HOST.rx[i], cmd_decoder_pkg::VERSION_STR[127-8*i -: 8]);
  endtask
  task t_host_area;
    slow <= 1'b1;
    fill(8'h30);
    cmd(8'h02, 8'h10, 8'h42);
    fork
      cmd(8'h03, 8'h00, 8'h43);
      begin
        repeat (8) @(posedge clk);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    for (int i = 0; i < 16; i++) check8(HOST.rx[i], 8'h30 + i[7:0]);
    slow <= 1'b0;
  endtask
  task t_display_boot;
    fill(8'h61);
    cmd(8'h07, 8'h10, 8'h47);
    fill(8'h41);
    cmd(8'h08, 8'h10, 8'h48);
    rd_disp(5'h03, 8'h64);
    rd_disp(5'h13, 8'h44);
    cmd(8'h04, 8'h00, 8'h44);
    cmd(8'h06, 8'h00, 8'h46);
    rd_disp(5'h1f, 8'h20);
    check8({3'h0, cursor_row, cursor_col}, 8'h00);
    magic({8'h08, 8'h12, 8'h63});
    cmd(8'h05, 8'h03, 8'h45);
    cmd(8'h00, 8'h00, 8'h40);
    rd_disp(5'h03, 8'h64);
    check8(8'(n_boot), 8'h01);
    check8(8'(n_rest), 8'h01);
  endtask
  task t_host_pins;
    magic({8'h0c, 8'h1c, 8'h61});
    cmd(8'h05, 8'h03, 8'h45);
    cmd(8'h00, 8'h00, 8'h40);
    check8(8'(hi_rst), 8'(RST_CYC));
    magic({8'h03, 8'h0b, 8'h5f});
    cmd(8'h05, 8'h03, 8'h45);
    cmd(8'h00, 8'h00, 8'h40);
    check8(8'(hi_pwr), 8'(PWR_CYC));
    {gpio2_user, gpio3_user} <= 2'h3;
    cmd(8'h05, 8'h03, 8'h45);
    magic({8'h0c, 8'h1c, 8'h61});
    cmd(8'h05, 8'h03, 8'h45);
    cmd(8'h00, 8'h00, 8'h40);
    check8(8'(hi_pwr), 8'(PWR_CYC));
    check8(8'(hi_rst), 8'(RST_CYC));
    {gpio2_user, gpio3_user} <= 2'h0;
  endtask
  task t_errors;
    magic({8'h08, 8'h12, 8'h64});
    cmd(8'h05, 8'h03, 8'hc5);
    cmd(8'h07, 8'h0f, 8'hc7);
    rd_disp(5'h00, 8'h61);
    cmd(8'h09, 8'h00, 8'hc9);
    cmd(8'h81, 8'h00, 8'hc1);
    cmd(8'h00, 8'h13, 8'hc0);
    check8(8'(n_rest), 8'h05);
  endtask
  // Reset, then each scenario in turn
  initial begin
    {sys_rst, clk_en} = 2'h3;
    {slow, gpio2_user, gpio3_user} = 3'h0;
    pwr_pulse_cycles = PWR_CYC;
    disp_rd_addr = 5'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_echo_version;
    t_host_area;
    t_display_boot;
    t_host_pins;
    t_errors;
    complete_run;
  end
endmodule // display_module_command_decoder_test
bind display_module_command_decoder decoder_monitor #(
  .BOOT_HOLD_CYCLES(BOOT_HOLD_CYCLES), .HOST_RST_CYCLES(HOST_RST_CYCLES)) MON (
  .clk(clk), .sys_rst(sys_rst), .in_hdr_valid(in_hdr_valid), .in_hdr_ready(in_hdr_ready),
  .in_type(in_type), .in_len(in_len), .out_hdr_valid(out_hdr_valid), .out_type(out_type),
  .out_len(out_len), .cursor_col(cursor_col), .cursor_row(cursor_row),
  .gpio2_user(gpio2_user), .pwr_pulse_cycles(pwr_pulse_cycles),
  .host_rst_out(host_rst_out), .host_pwr_out(host_pwr_out), .restart(restart));
`default_nettype wire

// *** hold_timer.sv ***
// Down counter used for pin pulses and the boot hold-off
`default_nettype none
module hold_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Load and status
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic             expired
);
  logic [31:0] count;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Load wins over counting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (clk_en) begin
      if (load) begin
        count <= load_val;
      end else if (count != '0) begin
        count <= count - 32'h1;
      end
    end
  end

  assign expired = (count == '0);
endmodule // hold_timer
`default_nettype wire

// *** host_model.sv ***
// Host model that sends commands and collects answers
`default_nettype none
module host_model (
  // Clock and stall mode
  input wire logic       clk,
  input wire logic       slow,
  // Command side
  output logic           hdr_v,
  input wire logic       hdr_r,
  output logic [7:0]     typ,
  output logic [7:0]     len,
  output logic           byt_v,
  input wire logic       byt_r,
  output logic [7:0]     byt,
  // Answer side
  input wire logic       ans_v,
  output logic           ans_r,
  input wire logic [7:0] ans_typ,
  input wire logic [7:0] ans_len,
  input wire logic       ab_v,
  output logic           ab_r,
  input wire logic [7:0] ab
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx [0:18];
  logic [7:0] rx [0:15];
  logic [7:0] r_typ;
  logic [7:0] r_len;
  // Idle levels
  initial begin
    {hdr_v, byt_v, ans_r, ab_r} = 4'h0;
    {typ, len, byt} = 24'h0;
  end
  // Answer readiness, stalling every other cycle when slow
  always @(posedge clk) begin
    ans_r <= slow ? ~ans_r : 1'b1;
    ab_r  <= slow ? ~ab_r : 1'b1;
  end
  // One command out, its whole answer back
  task automatic xfer(input logic [7:0] t, input logic [7:0] l);
    int i;
    @(posedge clk);
    hdr_v <= 1'b1;
    typ <= t;
    len <= l;
    @(posedge clk iff hdr_r);
    hdr_v <= 1'b0;
    typ <= ~t;
    len <= ~l;
    for (i = 0; i < l; i++) begin
      byt_v <= 1'b1;
      byt <= tx[i];
      @(posedge clk iff byt_r);
    end
    byt_v <= 1'b0;
    byt <= ~byt;
    @(posedge clk iff ans_v && ans_r);
    r_typ = ans_typ;
    r_len = ans_len;
    for (i = 0; i < r_len && i < 16; i++) begin
      @(posedge clk iff ab_v && ab_r);
      rx[i] = ab;
    end
  endtask
endmodule // host_model
`default_nettype wire
